// *** src/itm_pkg.sv ***
package itm_pkg;
   ////////////////////////////////////////////////////////////////////////////////
   // register byte offsets on the wishbone port
   localparam logic [4:0] ITM_ADR_CNT0 = 5'h00;
   localparam logic [4:0] ITM_ADR_CNT1 = 5'h04;
   localparam logic [4:0] ITM_ADR_CNT2 = 5'h08;
   localparam logic [4:0] ITM_ADR_CTRL = 5'h0c;
   localparam logic [4:0] ITM_ADR_STAT = 5'h10;
   localparam logic [4:0] ITM_ADR_MASK = 5'h14;
   localparam logic [4:0] ITM_ADR_OUTS = 5'h18;
   localparam int ITM_NUM_CNT = 3;
   localparam int ITM_CNT_W = 16;

   ////////////////////////////////////////////////////////////////////////////////
   // control word layout and encodings
   localparam int ITM_CW_SEL_POS = 6;
   localparam int ITM_CW_FMT_POS = 4;
   localparam int ITM_CW_MODE_POS = 1;
   localparam int ITM_CW_BCD_POS = 0;
   localparam logic [1:0] ITM_SEL_ILLEGAL = 2'h3;
   localparam logic [1:0] ITM_FMT_LATCH = 2'h0;
   localparam logic [1:0] ITM_FMT_LSB = 2'h1;
   localparam logic [1:0] ITM_FMT_MSB = 2'h2;
   localparam logic [1:0] ITM_FMT_BOTH = 2'h3;
   localparam logic [2:0] ITM_MODE_0 = 3'h0;
   localparam logic [2:0] ITM_MODE_1 = 3'h1;
   localparam logic [2:0] ITM_MODE_2 = 3'h2;
   localparam logic [2:0] ITM_MODE_3 = 3'h3;
   localparam logic [2:0] ITM_MODE_4 = 3'h4;
   localparam logic [2:0] ITM_MODE_5 = 3'h5;

   ////////////////////////////////////////////////////////////////////////////////
   // reset values
   localparam logic [1:0] ITM_FMT_RESET = ITM_FMT_BOTH;
   localparam logic [2:0] ITM_MODE_RESET = ITM_MODE_0;
   localparam logic [2:0] ITM_MASK_RESET = 3'h0;
   localparam logic [15:0] ITM_CNT_RESET = 16'h0000;

   // counter sequencing: idle has no count, armed loads on next tick
   typedef enum logic [3:0] {
      ITM_ST_IDLE = 4'b0001,
      ITM_ST_ARMED = 4'b0010,
      ITM_ST_RUN = 4'b0100,
      ITM_ST_DONE = 4'b1000
   } itm_state_type;

   // modes 2 and 3 ignore the top mode bit
   function automatic logic [2:0] itm_mode_norm(input logic [2:0] m);
      return m[1] ? {1'b0, m[1:0]} : m;
   endfunction

   // one step down; binary wraps 0 to ffff, decimal wraps 0000 to 9999
   function automatic logic [15:0] itm_dec(input logic [15:0] v, input logic bcd);
      logic [15:0] r;
      logic borrow;
      r = v - 16'h0001;
      borrow = 1'b1;
      if (bcd) begin
         for (int i = 0; i < 4; i++) begin
            r[4*i +: 4] = v[4*i +: 4];
            if (borrow) begin
               if (v[4*i +: 4] == 4'h0) begin
                  r[4*i +: 4] = 4'h9;
               end else begin
                  r[4*i +: 4] = v[4*i +: 4] - 4'h1;
                  borrow = 1'b0;
               end
            end
         end
      end
      return r;
   endfunction
endpackage

// *** src/itm_counter.sv ***
`timescale 1ns/1ns
module itm_counter (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cfg_wr_i,
   input wire logic [2:0] mode_i,
   input wire logic bcd_i,
   input wire logic load_i,
   input wire logic [itm_pkg::ITM_CNT_W-1:0] value_i,
   input wire logic tick_i,
   input wire logic gate_i,
   input wire logic gate_rise_i,
   output logic out_o,
   output logic [itm_pkg::ITM_CNT_W-1:0] count_o,
   output logic tc_o
);
   import itm_pkg::*;

   itm_state_type st_q, st_d;
   logic [2:0] mode_q, mode_d;
   logic bcd_q, bcd_d, out_q, out_d, trig_q, trig_d, tc_q, tc_d;
   logic [15:0] init_q, init_d, cnt_q, cnt_d, nxt;
   logic gate_ok, trig_mode;

   ////////////////////////////////////////////////////////////////////////////////
   // next state of one counter; the count advances only on a count tick, while loads, control words and triggers act in any cycle
   always_comb begin
      st_d = st_q;
      mode_d = mode_q;
      bcd_d = bcd_q;
      out_d = out_q;
      trig_d = trig_q;
      init_d = init_q;
      cnt_d = cnt_q;
      tc_d = 1'b0;
      nxt = itm_dec(cnt_q, bcd_q);
      gate_ok = gate_i || (mode_q == ITM_MODE_1) || (mode_q == ITM_MODE_5);
      trig_mode = (mode_q != ITM_MODE_0) && (mode_q != ITM_MODE_4);
      // a trigger before any count is loaded would fire a stale shot
      if (gate_rise_i && trig_mode && (st_q != ITM_ST_IDLE)) begin
         trig_d = 1'b1;
      end
      if (cfg_wr_i) begin
         mode_d = itm_mode_norm(mode_i);
         bcd_d = bcd_i;
         st_d = ITM_ST_IDLE;
         trig_d = 1'b0;
         out_d = (itm_mode_norm(mode_i) != ITM_MODE_0);
      end else begin
         if (load_i) begin
            init_d = value_i;
            case (mode_q)
               ITM_MODE_0: begin
                  st_d = ITM_ST_ARMED;
                  out_d = 1'b0;
               end
               ITM_MODE_4: st_d = ITM_ST_ARMED;
               ITM_MODE_2, ITM_MODE_3: begin
                  if (st_q == ITM_ST_IDLE) begin
                     st_d = ITM_ST_ARMED;
                  end
               end
               default: begin
                  // one-shot keeps its running count; new value waits for the trigger
                  if (st_q == ITM_ST_IDLE) begin
                     st_d = ITM_ST_DONE;
                  end
               end
            endcase
         end
         if (((mode_q == ITM_MODE_2) || (mode_q == ITM_MODE_3)) && !gate_i) begin
            out_d = 1'b1;
         end
         // a reload in modes 0 and 4 restarts the count, so a tick in the same cycle must not end it
         if (tick_i && !(load_i && ((mode_q == ITM_MODE_0) || (mode_q == ITM_MODE_4)))) begin
            if (trig_q && trig_mode) begin
               cnt_d = init_q;
               st_d = ITM_ST_RUN;
               trig_d = gate_rise_i;
               out_d = (mode_q != ITM_MODE_1);
            end else begin
               case (st_q)
                  ITM_ST_ARMED: begin
                     cnt_d = init_q;
                     st_d = ITM_ST_RUN;
                  end
                  ITM_ST_RUN: begin
                     if (gate_ok) begin
                        cnt_d = nxt;
                        if (mode_q == ITM_MODE_3) begin
                           out_d = (nxt == 16'h0000) || (nxt > (init_q >> 1));
                        end else if (mode_q != ITM_MODE_0 && mode_q != ITM_MODE_1) begin
                           out_d = 1'b1;
                        end
                        if (nxt == 16'h0000) begin
                           tc_d = 1'b1;
                           case (mode_q)
                              ITM_MODE_2: begin
                                 cnt_d = init_q;
                                 out_d = 1'b0;
                              end
                              ITM_MODE_3: cnt_d = init_q;
                              default: begin
                                 st_d = ITM_ST_DONE;
                                 out_d = (mode_q == ITM_MODE_0) || (mode_q == ITM_MODE_1);
                              end
                           endcase
                        end
                     end
                  end
                  ITM_ST_DONE: begin
                     if ((mode_q == ITM_MODE_4) || (mode_q == ITM_MODE_5)) begin
                        out_d = 1'b1;
                     end
                  end
                  default: ;
               endcase
            end
         end
      end
   end

   // register stage of the counter
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q <= ITM_ST_IDLE;
         mode_q <= ITM_MODE_RESET;
         bcd_q <= 1'b0;
         out_q <= 1'b1;
         trig_q <= 1'b0;
         init_q <= ITM_CNT_RESET;
         cnt_q <= ITM_CNT_RESET;
         tc_q <= 1'b0;
      end else begin
         st_q <= st_d;
         mode_q <= mode_d;
         bcd_q <= bcd_d;
         out_q <= out_d;
         trig_q <= trig_d;
         init_q <= init_d;
         cnt_q <= cnt_d;
         tc_q <= tc_d;
      end
   end

   assign out_o = out_q;
   assign count_o = cnt_q;
   assign tc_o = tc_q;

   ////////////////////////////////////////////////////////////////////////////////
   property p_mode0_load_low;
      @(posedge clk_i) disable iff (rst_i)
      (!cfg_wr_i && load_i && mode_q == ITM_MODE_0) |=> !out_q;
   endproperty
   a_mode0_load_low: assert property (p_mode0_load_low) else $error("mode 0 output not low after load");

   property p_mode0_hold_high;
      @(posedge clk_i) disable iff (rst_i)
      (mode_q == ITM_MODE_0 && st_q == ITM_ST_DONE && out_q && !load_i && !cfg_wr_i) |=> out_q;
   endproperty
   a_mode0_hold_high: assert property (p_mode0_hold_high) else $error("mode 0 output fell without reload");

   property p_mode1_fire;
      @(posedge clk_i) disable iff (rst_i)
      (mode_q == ITM_MODE_1 && trig_q && tick_i && !cfg_wr_i) |=> (!out_q && cnt_q == $past(init_q));
   endproperty
   a_mode1_fire: assert property (p_mode1_fire) else $error("one-shot did not start on trigger tick");

   property p_tc_high;
      @(posedge clk_i) disable iff (rst_i)
      (tc_q && (mode_q == ITM_MODE_0 || mode_q == ITM_MODE_1)) |-> (out_q && cnt_q == 16'h0000);
   endproperty
   a_tc_high: assert property (p_tc_high) else $error("output not high at terminal count");

   property p_reload_keeps_pulse;
      @(posedge clk_i) disable iff (rst_i)
      (mode_q == ITM_MODE_1 && load_i && !out_q && !tick_i && !cfg_wr_i) |=>
         (cnt_q == $past(cnt_q) && !out_q && init_q == $past(value_i));
   endproperty
   a_reload_keeps_pulse: assert property (p_reload_keeps_pulse) else $error("reload disturbed one-shot");

   property p_last_step;
      @(posedge clk_i) disable iff (rst_i)
      (st_q == ITM_ST_RUN && tick_i && gate_i && !trig_q && !cfg_wr_i && !load_i && cnt_q == 16'h0001)
         |=> (tc_q && (cnt_q == 16'h0000 || cnt_q == $past(init_q))) ##1 !tc_q;
   endproperty
   a_last_step: assert property (p_last_step) else $error("terminal count not flagged once");
endmodule

// *** src/itm_timer.sv ***
// Decided for this implementation: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ns
// Notes on behaviour
// - control word: select, format, mode, decimal bit
// - count bytes accepted anytime, other words between
// - six modes; top bit ignored for 2, 3
// - mode 0: output low once count loaded
// - mode 0: high after terminal until reload
// - mode 1: low on tick after gate rise
// - mode 1: high again at terminal count
// - mode 1: reload only affects next trigger
// - count readable anytime without disturbing counting
// - formats: latch, lsb, msb, lsb then msb
// - binary or decimal; zero gives full range
module itm_timer (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [itm_pkg::ITM_NUM_CNT-1:0] count_clk_i,
   input wire logic [itm_pkg::ITM_NUM_CNT-1:0] gate_i,
   output logic [itm_pkg::ITM_NUM_CNT-1:0] timer_out_o,
   output logic irq_o
);
   import itm_pkg::*;

   // pin synchronisers: count clocks in the low half, gates in the high half
   logic [5:0] s1_q, s2_q, s3_q, lvl_q, lvl_d, rise_q, rise_d;
   logic [2:0] gate_lvl, tick, gate_rise;
   // bus and per-counter access state
   logic ack_q, ack_d, irq_q, irq_d;
   logic [31:0] dat_q, dat_d;
   logic [2:0] mask_q, mask_d, stat_q, stat_d, stat_clr;
   logic [2:0][1:0] fmt_q, fmt_d;
   logic [2:0] wr_hi_q, wr_hi_d, rd_hi_q, rd_hi_d, latched_q, latched_d;
   logic [2:0][15:0] latch_q, latch_d, cnt;
   logic [2:0][7:0] hold_q, hold_d;
   logic [2:0] cfg_wr, ld, tout, tc;
   logic [15:0] ld_val, rv;
   logic req, wr_en, rd_en, is_cnt, hi;
   logic [4:0] adr_lo;
   logic [7:0] wbyte;
   logic [1:0] c;

   ////////////////////////////////////////////////////////////////////////////////
   // three-stage sampling; a level change counts once stages two and three agree
   always_comb begin
      lvl_d = lvl_q;
      for (int i = 0; i < 6; i++) begin
         if (s2_q[i] == s3_q[i]) begin
            lvl_d[i] = s3_q[i];
         end
      end
      rise_d = lvl_d & ~lvl_q;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s1_q <= 6'h00;
         s2_q <= 6'h00;
         s3_q <= 6'h00;
         lvl_q <= 6'h00;
         rise_q <= 6'h00;
      end else begin
         s1_q <= {gate_i, count_clk_i};
         s2_q <= s1_q;
         s3_q <= s2_q;
         lvl_q <= lvl_d;
         rise_q <= rise_d;
      end
   end

   assign tick = rise_q[2:0];
   assign gate_rise = rise_q[5:3];
   assign gate_lvl = lvl_q[5:3];

   ////////////////////////////////////////////////////////////////////////////////
   // bus decode; one request is taken per ack, so ack is a single-cycle pulse
   assign req = wb_cyc_i && wb_stb_i && !ack_q;
   assign wr_en = req && wb_we_i && wb_sel_i[0];
   assign rd_en = req && !wb_we_i;
   assign adr_lo = wb_adr_i[4:0];
   assign wbyte = wb_dat_i[7:0];
   assign is_cnt = (wb_adr_i[31:5] == 27'h0000000) && (adr_lo[1:0] == 2'h0) && (adr_lo < ITM_ADR_CTRL);

   // register file, byte sequencing and read-back
   always_comb begin
      ack_d = req;
      dat_d = 32'h00000000;
      fmt_d = fmt_q;
      wr_hi_d = wr_hi_q;
      rd_hi_d = rd_hi_q;
      latched_d = latched_q;
      latch_d = latch_q;
      hold_d = hold_q;
      mask_d = mask_q;
      stat_clr = 3'h0;
      cfg_wr = 3'h0;
      ld = 3'h0;
      ld_val = {wbyte, hold_q[0]};
      rv = 16'h0000;
      hi = 1'b0;
      c = adr_lo[3:2];
      // count bytes: a two-byte counter pairs lsb then msb, independent of the others
      if (wr_en && is_cnt) begin
         case (fmt_q[c])
            ITM_FMT_LSB: begin
               ld[c] = 1'b1;
               ld_val = {8'h00, wbyte};
            end
            ITM_FMT_MSB: begin
               ld[c] = 1'b1;
               ld_val = {wbyte, 8'h00};
            end
            ITM_FMT_BOTH: begin
               if (!wr_hi_q[c]) begin
                  hold_d[c] = wbyte;
                  wr_hi_d[c] = 1'b1;
               end else begin
                  ld[c] = 1'b1;
                  ld_val = {wbyte, hold_q[c]};
                  wr_hi_d[c] = 1'b0;
               end
            end
            default: ;
         endcase
      end
      // control word; the illegal select is dropped whole
      if (wr_en && wb_adr_i[31:5] == 27'h0000000 && adr_lo == ITM_ADR_CTRL &&
          wbyte[ITM_CW_SEL_POS +: 2] != ITM_SEL_ILLEGAL) begin
         c = wbyte[ITM_CW_SEL_POS +: 2];
         if (wbyte[ITM_CW_FMT_POS +: 2] == ITM_FMT_LATCH) begin
            // a second latch before the read keeps the first snapshot
            if (!latched_q[c]) begin
               latched_d[c] = 1'b1;
               latch_d[c] = cnt[c];
            end
         end else begin
            fmt_d[c] = wbyte[ITM_CW_FMT_POS +: 2];
            wr_hi_d[c] = 1'b0;
            rd_hi_d[c] = 1'b0;
            latched_d[c] = 1'b0;
            cfg_wr[c] = 1'b1;
         end
      end
      if (wr_en && wb_adr_i[31:5] == 27'h0000000 && adr_lo == ITM_ADR_MASK) begin
         mask_d = wbyte[2:0];
      end
      if (rd_en && is_cnt) begin
         // reads only look at the count; the counter itself is never touched
         rv = latched_q[c] ? latch_q[c] : cnt[c];
         hi = (fmt_q[c] == ITM_FMT_MSB) || (fmt_q[c] == ITM_FMT_BOTH && rd_hi_q[c]);
         dat_d = {24'h000000, hi ? rv[15:8] : rv[7:0]};
         if (fmt_q[c] == ITM_FMT_BOTH) begin
            rd_hi_d[c] = !rd_hi_q[c];
         end
         if (fmt_q[c] != ITM_FMT_BOTH || rd_hi_q[c]) begin
            latched_d[c] = 1'b0;
         end
      end else if (rd_en && wb_adr_i[31:5] == 27'h0000000) begin
         case (adr_lo)
            ITM_ADR_STAT: begin
               dat_d = {29'h00000000, stat_q};
               stat_clr = 3'h7;
            end
            ITM_ADR_MASK: dat_d = {29'h00000000, mask_q};
            ITM_ADR_OUTS: dat_d = {29'h00000000, tout};
            default: ;
         endcase
      end
      // terminal counts win over a clearing read in the same cycle
      stat_d = (stat_q & ~stat_clr) | tc;
      irq_d = |(stat_d & mask_d);
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
         dat_q <= 32'h00000000;
         fmt_q <= {ITM_FMT_RESET, ITM_FMT_RESET, ITM_FMT_RESET};
         wr_hi_q <= 3'h0;
         rd_hi_q <= 3'h0;
         latched_q <= 3'h0;
         latch_q <= {ITM_CNT_RESET, ITM_CNT_RESET, ITM_CNT_RESET};
         hold_q <= 24'h000000;
         mask_q <= ITM_MASK_RESET;
         stat_q <= 3'h0;
         irq_q <= 1'b0;
      end else begin
         ack_q <= ack_d;
         dat_q <= dat_d;
         fmt_q <= fmt_d;
         wr_hi_q <= wr_hi_d;
         rd_hi_q <= rd_hi_d;
         latched_q <= latched_d;
         latch_q <= latch_d;
         hold_q <= hold_d;
         mask_q <= mask_d;
         stat_q <= stat_d;
         irq_q <= irq_d;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;
   assign irq_o = irq_q;
   assign timer_out_o = tout;

   ////////////////////////////////////////////////////////////////////////////////
   // the three counters share the load bus; only one is strobed per cycle
   for (genvar g = 0; g < ITM_NUM_CNT; g++) begin : g_cnt
      itm_counter u_cnt (
         .clk_i(clk_i),
         .rst_i(rst_i),
         .cfg_wr_i(cfg_wr[g]),
         .mode_i(wbyte[ITM_CW_MODE_POS +: 3]),
         .bcd_i(wbyte[ITM_CW_BCD_POS]),
         .load_i(ld[g]),
         .value_i(ld_val),
         .tick_i(tick[g]),
         .gate_i(gate_lvl[g]),
         .gate_rise_i(gate_rise[g]),
         .out_o(tout[g]),
         .count_o(cnt[g]),
         .tc_o(tc[g])
      );
   end

   ////////////////////////////////////////////////////////////////////////////////
   property p_ack_pulse;
      @(posedge clk_i) disable iff (rst_i)
      (wb_cyc_i && wb_stb_i && !ack_q) |=> ack_q ##1 !ack_q;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack not a one-cycle answer");

   property p_ctrl_decode;
      @(posedge clk_i) disable iff (rst_i)
      (wr_en && adr_lo == ITM_ADR_CTRL && wb_adr_i[31:5] == 27'h0000000 && wbyte[7:6] == 2'h1 &&
       wbyte[5:4] != ITM_FMT_LATCH) |=> (fmt_q[1] == $past(wbyte[5:4]) && !wr_hi_q[1] && $stable(fmt_q[0]));
   endproperty
   a_ctrl_decode: assert property (p_ctrl_decode) else $error("control word not applied to counter 1");

   property p_illegal_sel;
      @(posedge clk_i) disable iff (rst_i)
      (wr_en && adr_lo == ITM_ADR_CTRL && wbyte[7:6] == ITM_SEL_ILLEGAL) |=>
         ($stable(fmt_q) && $stable(latched_q) && $stable(wr_hi_q));
   endproperty
   a_illegal_sel: assert property (p_illegal_sel) else $error("illegal select changed a counter");

   property p_latch_hold;
      @(posedge clk_i) disable iff (rst_i)
      (wr_en && adr_lo == ITM_ADR_CTRL && wb_adr_i[31:5] == 27'h0000000 && wbyte == 8'h00 && !latched_q[0])
         |=> (latched_q[0] && latch_q[0] == $past(cnt[0])) ##1 $stable(latch_q[0]);
   endproperty
   a_latch_hold: assert property (p_latch_hold) else $error("latched count not held");

   property p_byte_pair;
      @(posedge clk_i) disable iff (rst_i)
      (wr_en && is_cnt && adr_lo == ITM_ADR_CNT2 && fmt_q[2] == ITM_FMT_BOTH && !wr_hi_q[2])
         |-> (!ld[2]) ##1 wr_hi_q[2];
   endproperty
   a_byte_pair: assert property (p_byte_pair) else $error("first count byte loaded counter");

   property p_irq_follows;
      @(posedge clk_i) disable iff (rst_i)
      (tc[0] && mask_q[0] && !(wr_en && adr_lo == ITM_ADR_MASK)) |=> (irq_q && stat_q[0]);
   endproperty
   a_irq_follows: assert property (p_irq_follows) else $error("unmasked event raised no interrupt");

   // status, mask and interrupt are registered together, so the level never lags its sources
   property p_irq_level;
      @(posedge clk_i) disable iff (rst_i)
      irq_q == |(stat_q & mask_q);
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("interrupt level disagrees with status");

   property p_stat_clear;
      @(posedge clk_i) disable iff (rst_i)
      (rd_en && wb_adr_i[31:5] == 27'h0000000 && adr_lo == ITM_ADR_STAT && tc == 3'h0) |=> (stat_q == 3'h0);
   endproperty
   a_stat_clear: assert property (p_stat_clear) else $error("status read left events set");

   // reads must never strobe a counter, or a running one-shot would be disturbed
   property p_read_no_disturb;
      @(posedge clk_i) disable iff (rst_i)
      rd_en |-> (ld == 3'h0 && cfg_wr == 3'h0);
   endproperty
   a_read_no_disturb: assert property (p_read_no_disturb) else $error("read touched a counter");

   property p_msb_completes;
      @(posedge clk_i) disable iff (rst_i)
      (wr_en && is_cnt && adr_lo == ITM_ADR_CNT1 && fmt_q[1] == ITM_FMT_BOTH && wr_hi_q[1]) |->
         (ld[1] && ld_val[15:8] == wbyte && ld_val[7:0] == hold_q[1]) ##1 !wr_hi_q[1];
   endproperty
   a_msb_completes: assert property (p_msb_completes) else $error("second count byte did not load");

   // read data is only meaningful with ack, so it is kept at zero elsewhere
   property p_dat_quiet;
      @(posedge clk_i) disable iff (rst_i)
      !ack_q |-> (dat_q == 32'h00000000);
   endproperty
   a_dat_quiet: assert property (p_dat_quiet) else $error("read data shown without ack");
endmodule

// *** verification/itm_pins.sv ***
`timescale 1ns/1ns
// far-side count clocks: 4 clk high, 4 clk low, parked low while disabled
module itm_pins (
   input wire logic clk_i,
   input wire logic [2:0] en_i,
   output logic [2:0] count_clk_o
);
   logic [2:0] ph [3];
   // keeps both phases above the 2-cycle minimum so no edge is lost
   always_ff @(posedge clk_i) begin
      for (int i = 0; i < 3; i++) begin
         ph[i] <= en_i[i] ? ph[i] + 3'h1 : 3'h0;
         count_clk_o[i] <= en_i[i] & ph[i][2];
      end
   end
endmodule

// *** verification/tb.sv ***
`timescale 1ns/1ns
module tb;
   import itm_pkg::*;
   logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [31:0] adr = 32'h0, wdat = 32'h0, rdat, wb_dat_o;
   logic wb_ack_o, irq_o;
   logic [2:0] en = 3'h0, gate = 3'h5, cclk, tout;
   logic [7:0] rows [4][3] = '{'{8'h30, 8'h03, 8'h04}, '{8'h31, 8'h10, 8'h0b},
      '{8'h10, 8'h05, 8'h06}, '{8'h20, 8'h01, 8'h00}};
   int errors = 0, tests_run = 0, n;
   time t0;
   ////////////////////////////////////////////////////////////
   // clock, design and pin model
   initial begin
      forever #5 clk_i = ~clk_i;
   end
   itm_timer dut_u (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .count_clk_i(cclk), .gate_i(gate), .timer_out_o(tout), .irq_o(irq_o));
   itm_pins pins_u (.clk_i(clk_i), .en_i(en), .count_clk_o(cclk));
   ////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // one classic cycle; the request stands until ack is sampled high at a rising edge
   task automatic wb(input logic w, input logic [4:0] a, input logic [7:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {27'h0, a};
      wdat <= {24'h0, d};
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      rdat = wb_dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   // counts count-pin rises until the output reaches the level
   task automatic wait_out(input int i, input logic lvl);
      logic p;
      n = 0;
      p = cclk[i];
      while (tout[i] !== lvl) begin
         @(negedge clk_i);
         if (cclk[i] && !p) n++;
         p = cclk[i];
      end
   endtask
   task automatic report_and_stop();
      $display("compares %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   task automatic t_reset();
      chk(tout, 3'h7);
      chk(irq_o, 1'b0);
      wb(1'b0, ITM_ADR_MASK, 8'h0);
      chk(rdat, 32'h0);
      wb(1'b0, 5'h1c, 8'h0);
      chk(rdat, 32'h0);
      $display("test reset done");
   endtask
   // mode 0 in every load format, binary and decimal
   task automatic t_mode0();
      wb(1'b1, ITM_ADR_MASK, 8'h01);
      for (int r = 0; r < 4; r++) begin
         wb(1'b1, ITM_ADR_CTRL, rows[r][0]);
         wb(1'b1, ITM_ADR_CNT0, rows[r][1]);
         if (rows[r][0][5:4] == 2'h3) wb(1'b1, ITM_ADR_CNT0, 8'h00);
         chk(tout[0], 1'b0);
         en[0] <= 1'b1;
         wait_out(0, 1'b1);
         chk(n, (r == 3) ? 32'h101 : rows[r][2]);
         // the event reaches status and interrupt one cycle after the output
         repeat (2) @(negedge clk_i);
         chk(irq_o, 1'b1);
         wb(1'b0, ITM_ADR_STAT, 8'h0);
         chk(rdat, 32'h1);
         wb(1'b0, ITM_ADR_STAT, 8'h0);
         chk(rdat, 32'h0);
         chk(irq_o, 1'b0);
         repeat (40) @(negedge clk_i);
         chk(tout[0], 1'b1);
         @(posedge clk_i);
         en[0] <= 1'b0;
      end
      wb(1'b1, ITM_ADR_CTRL, 8'h30);
      chk(tout[0], 1'b0);
      $display("test mode0 done");
   endtask
   // one-shot with a latched read and a reload inside the pulse
   task automatic t_mode1();
      wb(1'b1, ITM_ADR_CTRL, 8'h72);
      chk(tout[1], 1'b1);
      wb(1'b1, ITM_ADR_CTRL, 8'hb0);
      chk(tout[2], 1'b0);
      wb(1'b1, ITM_ADR_CNT1, 8'h04);
      wb(1'b1, ITM_ADR_CNT1, 8'h00);
      wb(1'b1, ITM_ADR_CNT2, 8'h07);
      wb(1'b1, ITM_ADR_CNT2, 8'h00);
      en[1] <= 1'b1;
      repeat (30) @(negedge clk_i);
      chk(tout[1], 1'b1);
      @(posedge clk_i);
      gate[1] <= 1'b1;
      wait_out(1, 1'b0);
      t0 = $time;
      chk(n <= 2, 1'b1);
      wb(1'b1, ITM_ADR_CTRL, 8'h40);
      wb(1'b0, ITM_ADR_CNT1, 8'h0);
      chk(rdat > 0 && rdat <= 4, 1'b1);
      wb(1'b0, ITM_ADR_CNT1, 8'h0);
      chk(rdat, 32'h0);
      wb(1'b1, ITM_ADR_CNT1, 8'h0a);
      wb(1'b1, ITM_ADR_CNT1, 8'h00);
      wait_out(1, 1'b1);
      chk(32'($time - t0), 32'h140);
      @(posedge clk_i);
      gate[1] <= 1'b0;
      repeat (10) @(posedge clk_i);
      gate[1] <= 1'b1;
      wait_out(1, 1'b0);
      t0 = $time;
      wait_out(1, 1'b1);
      chk(32'($time - t0), 32'h320);
      $display("test mode1 done");
   endtask
   task automatic t_illegal();
      wb(1'b1, ITM_ADR_CTRL, 8'hf2);
      chk(tout, 3'h2);
      wb(1'b0, ITM_ADR_OUTS, 8'h0);
      chk(rdat, 32'h2);
      wb(1'b1, ITM_ADR_CTRL, 8'h00);
      wb(1'b0, ITM_ADR_CNT0, 8'h0);
      chk(rdat, 32'h0);
      wb(1'b0, ITM_ADR_CNT0, 8'h0);
      chk(rdat, 32'h0);
      wb(1'b1, ITM_ADR_CTRL, 8'hbc);
      chk(tout[2], 1'b1);
      $display("test illegal done");
   endtask
   ////////////////////////////////////////////////////////////
   // main sequence after a 12-cycle reset
   initial begin
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_mode0();
      t_mode1();
      t_illegal();
      report_and_stop();
   end
   // watchdog well past the few thousand cycles the tests need
   initial begin
      repeat (30000) @(posedge clk_i);
      errors++;
      report_and_stop();
   end
endmodule
